// file: hw/srf_defs.vh
`ifndef SRF_DEFS_VH
`define SRF_DEFS_VH
// How it works
// - Status bits 15:14 are loaded when the chip select falls.
// - On chip select rise in FIFO mode the queue head moves into the reply and leaves.
// - Fault codes live in the range 001 to 01F of the contents field.
// - Channel faults queue per occurrence; a global fault once while it lasts.
// - Bit 13 gives the whole reply word odd parity.
// - Bit 12 is the data-lost flag; bits 11:0 carry the queue contents.
// - A push into a full queue drops the entry and sets data lost.
// - Status: 00 off, 01 on idle, 10 on processing, 11 config report.
// - With no fault and an empty queue the contents read zero.
// - Bad frame bit count queues global code 2 on channel 0 only, once.
// - Current limit queues code 10; serial parity error queues code 12.
// - A protocol: no idle after bit 19 queues code 1A.
// - A protocol: reserved 18, bit time or too few 19, CRC 1C.
// - A protocol: data 020 to FFF is queued unchanged as data.
// - A protocol: data below 020 queues the reserved-message code instead.
// - B protocol: satellite parity error gives 1C; 18 is never used.
// - B protocol: bit 11 is 1 for data and 0 for faults.
// - B protocol data of 8 to 11 bits is right-justified, upper bits zero.
// - Each queue holds two entries; flush empties the addressed queue.
// - The first reply after reset is the main config on any channel; then, without CCR, FIFO or a config write, channel 0 sends it, others send E000.

`define SRF_FRAME_BITS   5'h10
`define SRF_BIT_STAT     15
`define SRF_BIT_PAR      13
`define SRF_BIT_LOST     12

`define SRF_CODE_NONE    12'h000
`define SRF_CODE_BADCNT  12'h002
`define SRF_CODE_CURLIM  12'h010
`define SRF_CODE_SPIPAR  12'h012
`define SRF_CODE_RESV    12'h018
`define SRF_CODE_BITTIME 12'h019
`define SRF_CODE_TOOMANY 12'h01A
`define SRF_CODE_CHECK   12'h01C
`define SRF_DATA_MIN     12'h020
`define SRF_B_DATA_FLAG  12'h800

`define SRF_KIND_DATA    2'h0
`define SRF_KIND_BITTIME 2'h1
`define SRF_KIND_TOOMANY 2'h2
`define SRF_KIND_CHECK   2'h3

`define SRF_MODE_AUTO    2'h0
`define SRF_MODE_MAIN    2'h1
`define SRF_MODE_CCR     2'h2
`define SRF_MODE_FIFO    2'h3

`define SRF_SEL_MAIN     4'h1
`define SRF_SEL_CCR      4'h2
`define SRF_SEL_ZERO     4'h4
`define SRF_SEL_FIFO     4'h8

`define SRF_STAT_OFF     2'h0
`define SRF_STAT_IDLE    2'h1
`define SRF_STAT_RUN     2'h2
`define SRF_STAT_CFG     2'h3

`define SRF_GLOBAL_CHAN  2'h0
`endif

// file: hw/srf_sync.v
`timescale 1ns/1ps
module srf_sync #(
    parameter             WIDTH = 2,
    // Reset to the pin's idle level, so no false edge follows reset
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             clkEn,
    input  wire [WIDTH-1:0] asyncIn,
    output reg  [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stage1;

    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            stage1  <= INIT;
            syncOut <= INIT;
        end
        else if (clkEn)
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // srf_sync

// file: hw/srf_fifo.v
`timescale 1ns/1ps
module srf_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 8
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             clkEn,
    input  wire             flush,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam integer  LASTI = DEPTH - 1;
    localparam integer  FULLI = DEPTH;
    localparam [AW-1:0] LAST  = LASTI[AW-1:0];
    localparam [AW:0]   FULL  = FULLI[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            doPush;
    wire            doPop;

    assign inReady  = (count != FULL);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign doPush   = inValid & inReady;
    assign doPop    = outValid & outReady;

    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end
        else if (clkEn)
        begin
            // Flush wins: a push in the same cycle is dropped with the rest
            if (flush)
            begin
                wrPtr <= {AW{1'b0}};
                rdPtr <= {AW{1'b0}};
                count <= {(AW+1){1'b0}};
            end
            else
            begin
                if (doPush)
                begin
                    mem[wrPtr] <= inData;
                    wrPtr <= (wrPtr == LAST) ? {AW{1'b0}} : wrPtr + 1'b1;
                end
                if (doPop)
                    rdPtr <= (rdPtr == LAST) ? {AW{1'b0}} : rdPtr + 1'b1;
                if (doPush && !doPop)
                    count <= count + 1'b1;
                else if (doPop && !doPush)
                    count <= count - 1'b1;
            end
        end
    end
endmodule // srf_fifo

// file: hw/srf_reply_formatter.v
`timescale 1ns/1ps
`include "srf_defs.vh"
module srf_reply_formatter #(
    parameter ING_DEPTH = 8,
    parameter Q_DEPTH   = 2
) (
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire        clkEn,
    input  wire        spiClk,
    input  wire        spiCsN,
    output reg         misoOut,
    output reg         misoOe,
    input  wire [1:0]  replyChan,
    input  wire [1:0]  replyMode,
    input  wire        replyCcrWrite,
    input  wire [12:0] mainConfig,
    input  wire [12:0] chanConfig,
    input  wire [7:0]  chanCtrl,
    input  wire [3:0]  protoB,
    input  wire [7:0]  bDataBits,
    input  wire        flushReq,
    input  wire [1:0]  flushChan,
    input  wire [3:0]  curLimitEvt,
    input  wire [3:0]  spiParityEvt,
    input  wire        decValid,
    output reg         decReady,
    input  wire [1:0]  decChan,
    input  wire [1:0]  decKind,
    input  wire [11:0] decData,
    output reg  [3:0]  dataLostFlag,
    output reg  [1:0]  statusBits,
    output reg         globalFault
);
    function [3:0] lowBit;
        input [3:0] v;
        begin
            lowBit = v & (~v + 4'h1);
        end
    endfunction

    function [1:0] chanOf;
        input [3:0] oneHot;
        begin
            case (oneHot)
                4'h2:    chanOf = 2'h1;
                4'h4:    chanOf = 2'h2;
                4'h8:    chanOf = 2'h3;
                default: chanOf = 2'h0;
            endcase
        end
    endfunction

    function [11:0] mapEntry;
        input [1:0]  kind;
        input [11:0] data;
        input        isB;
        input [1:0]  nBits;
        reg   [11:0] mask;
        begin
            mask = 12'h0FF;
            case (nBits)
                2'h1:    mask = 12'h1FF;
                2'h2:    mask = 12'h3FF;
                2'h3:    mask = 12'h7FF;
                default: mask = 12'h0FF;
            endcase
            case (kind)
                `SRF_KIND_DATA:
                    if (isB)
                        mapEntry = `SRF_B_DATA_FLAG | (data & mask);
                    else if (data < `SRF_DATA_MIN)
                        mapEntry = `SRF_CODE_RESV;
                    else
                        mapEntry = data;
                `SRF_KIND_BITTIME: mapEntry = `SRF_CODE_BITTIME;
                `SRF_KIND_TOOMANY: mapEntry = `SRF_CODE_TOOMANY;
                default:           mapEntry = `SRF_CODE_CHECK;
            endcase
        end
    endfunction

    function [1:0] statusOf;
        input [1:0] ctrl;
        begin
            case (ctrl)
                2'h1:    statusOf = `SRF_STAT_IDLE;
                2'h2:    statusOf = `SRF_STAT_RUN;
                default: statusOf = `SRF_STAT_OFF;
            endcase
        end
    endfunction

    // Link pins
    wire [1:0] pinSync;
    reg        sclkDly;
    reg        csDly;
    wire       sclkS = pinSync[1];
    wire       csS   = pinSync[0];
    wire       csFall   = csDly & ~csS;
    wire       csRise   = ~csDly & csS;
    wire       sclkRise = ~sclkDly & sclkS & ~csS;
    wire       sclkFall = sclkDly & ~sclkS & ~csS;

    srf_sync #(
        .WIDTH (2),
        .INIT  (2'h1)
    ) u_pinSync (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .clkEn   (clkEn),
        .asyncIn ({spiClk, spiCsN}),
        .syncOut (pinSync)
    );

    reg  [4:0]  bitCount;
    reg         globalSeen;
    reg         globalPend;
    reg  [3:0]  curPend;
    reg  [3:0]  parPend;
    reg         holdValid;
    reg  [13:0] holdWord;
    reg  [3:0]  replySel;
    reg  [1:0]  replyCh;
    reg  [12:0] fifoBody;
    reg  [15:0] shiftReg;
    wire        badFrame = csRise & (bitCount != `SRF_FRAME_BITS);

    // Event merge into the ingress buffer, global first
    reg         arbValid;
    reg  [13:0] arbWord;
    reg         grantGlob;
    reg  [3:0]  grantCur;
    reg  [3:0]  grantPar;
    reg         grantHold;
    wire        ingInReady;
    wire        ingOutValid;
    wire [13:0] ingOutData;
    wire        ingOutReady = ~csRise;

    always @*
    begin
        arbValid  = 1'b0;
        arbWord   = 14'h0000;
        grantGlob = 1'b0;
        grantCur  = 4'h0;
        grantPar  = 4'h0;
        grantHold = 1'b0;
        if (globalPend)
        begin
            arbValid  = 1'b1;
            arbWord   = {`SRF_GLOBAL_CHAN, `SRF_CODE_BADCNT};
            grantGlob = ingInReady;
        end
        else if (|curPend)
        begin
            arbValid = 1'b1;
            arbWord  = {chanOf(lowBit(curPend)), `SRF_CODE_CURLIM};
            grantCur = ingInReady ? lowBit(curPend) : 4'h0;
        end
        else if (|parPend)
        begin
            arbValid = 1'b1;
            arbWord  = {chanOf(lowBit(parPend)), `SRF_CODE_SPIPAR};
            grantPar = ingInReady ? lowBit(parPend) : 4'h0;
        end
        else if (holdValid)
        begin
            arbValid  = 1'b1;
            arbWord   = holdWord;
            grantHold = ingInReady;
        end
    end

    wire next_holdValid = (holdValid & ~grantHold) | (decValid & decReady);

    srf_fifo #(
        .WIDTH (14),
        .DEPTH (ING_DEPTH)
    ) u_ingress (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .flush    (1'b0),
        .inValid  (arbValid),
        .inReady  (ingInReady),
        .inData   (arbWord),
        .outValid (ingOutValid),
        .outReady (ingOutReady),
        .outData  (ingOutData)
    );

    // Per-channel two-entry queues
    wire [3:0]  qInReady;
    wire [3:0]  qPush;
    wire [3:0]  qOutValid;
    wire [47:0] qOutData;
    wire        popNow = csRise & (replyMode == `SRF_MODE_FIFO);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_queue
            assign qPush[gi] = ingOutValid & ingOutReady
                             & (ingOutData[13:12] == gi);
            srf_fifo #(
                .WIDTH (12),
                .DEPTH (Q_DEPTH)
            ) u_queue (
                .ref_clk  (ref_clk),
                .reset_n  (reset_n),
                .clkEn    (clkEn),
                .flush    (flushReq & (flushChan == gi)),
                .inValid  (qPush[gi]),
                .inReady  (qInReady[gi]),
                .inData   (ingOutData[11:0]),
                .outValid (qOutValid[gi]),
                .outReady (popNow & (replyChan == gi)),
                .outData  (qOutData[12*gi +: 12])
            );
        end
    endgenerate

    wire [3:0]  lostNow  = qPush & ~qInReady;
    wire [3:0]  popMask  = popNow ? (4'h1 << replyChan) : 4'h0;

    reg  [12:0] replyBody;
    reg  [1:0]  replyStat;
    wire [15:0] replyWord = {replyStat, ~^{replyStat, replyBody},
                             replyBody};

    always @*
    begin
        case (replySel)
            `SRF_SEL_MAIN:
            begin
                replyBody = mainConfig;
                replyStat = `SRF_STAT_CFG;
            end
            `SRF_SEL_CCR:
            begin
                replyBody = chanConfig;
                replyStat = `SRF_STAT_CFG;
            end
            `SRF_SEL_FIFO:
            begin
                replyBody = fifoBody;
                replyStat = statusOf(chanCtrl[2*replyCh +: 2]);
            end
            default:
            begin
                // Status 11 with zero body and parity 1 reads as E000
                replyBody = 13'h0000;
                replyStat = `SRF_STAT_CFG;
            end
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            sclkDly      <= 1'b0;
            csDly        <= 1'b1;
            bitCount     <= 5'h00;
            globalSeen   <= 1'b0;
            globalPend   <= 1'b0;
            curPend      <= 4'h0;
            parPend      <= 4'h0;
            holdValid    <= 1'b0;
            holdWord     <= 14'h0000;
            decReady     <= 1'b0;
            dataLostFlag <= 4'h0;
            replySel     <= `SRF_SEL_MAIN;
            replyCh      <= `SRF_GLOBAL_CHAN;
            fifoBody     <= 13'h0000;
            shiftReg     <= 16'h0000;
            statusBits   <= `SRF_STAT_OFF;
            misoOut      <= 1'b0;
            misoOe       <= 1'b0;
            globalFault  <= 1'b0;
        end
        else if (clkEn)
        begin
            sclkDly <= sclkS;
            csDly   <= csS;
            if (csFall)
                bitCount <= 5'h00;
            else if (sclkRise && bitCount != 5'h1F)
                bitCount <= bitCount + 5'h01;
            // A bad count persisting over frames queues its code only once
            if (csRise)
                globalSeen <= badFrame;
            globalFault <= csRise ? badFrame : globalFault;
            globalPend <= (badFrame & ~globalSeen) | (globalPend & ~grantGlob);
            curPend <= curLimitEvt | (curPend & ~grantCur);
            parPend <= spiParityEvt | (parPend & ~grantPar);
            holdValid <= next_holdValid;
            decReady  <= ~next_holdValid;
            if (decValid && decReady)
                holdWord <= {decChan, mapEntry(decKind, decData,
                             protoB[decChan], bDataBits[2*decChan +: 2])};
            // New loss beats the clear that follows its report
            dataLostFlag <= lostNow | (dataLostFlag & ~popMask);
            if (csRise)
            begin
                replyCh <= replyChan;
                if (replyMode == `SRF_MODE_FIFO)
                begin
                    replySel <= `SRF_SEL_FIFO;
                    fifoBody <= {dataLostFlag[replyChan],
                                 qOutValid[replyChan]
                                 ? qOutData[12*replyChan +: 12]
                                 : `SRF_CODE_NONE};
                end
                else if (replyMode == `SRF_MODE_CCR ||
                         (replyMode == `SRF_MODE_AUTO && replyCcrWrite))
                    replySel <= `SRF_SEL_CCR;
                else if (replyChan == `SRF_GLOBAL_CHAN)
                    replySel <= `SRF_SEL_MAIN;
                else
                    replySel <= `SRF_SEL_ZERO;
            end
            if (csFall)
            begin
                statusBits <= replyStat;
                misoOut    <= replyWord[15];
                shiftReg   <= {replyWord[14:0], 1'b0};
                misoOe     <= 1'b1;
            end
            else if (csRise)
                misoOe <= 1'b0;
            else if (sclkFall)
            begin
                misoOut  <= shiftReg[15];
                shiftReg <= {shiftReg[14:0], 1'b0};
            end
        end
    end
endmodule // srf_reply_formatter

// file: tb/srf_reply_formatter_props.sv
`timescale 1ns/1ps
module srf_reply_formatter_props #(
    parameter ING_DEPTH = 8,
    parameter Q_DEPTH   = 2
) (
    input wire       ref_clk,
    input wire       reset_n,
    input wire       spiClk,
    input wire       spiCsN,
    input wire       misoOut,
    input wire       misoOe,
    input wire       decValid,
    input wire       decReady,
    input wire [3:0] dataLostFlag,
    input wire [1:0] statusBits,
    input wire       globalFault
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_oe_idle: assert property (spiCsN [*6] |-> !misoOe)
        else $error("miso enabled outside a frame");
    a_oe_frame: assert property ((!spiCsN) [*6] |-> misoOe)
        else $error("miso not enabled inside a frame");
    a_oe_start: assert property ($rose(misoOe) |-> !spiCsN)
        else $error("miso enabled without chip select");
    a_status_load: assert property ($changed(statusBits) |-> !spiCsN)
        else $error("status changed outside a frame");
    a_lost_clear: assert property (
        |(~dataLostFlag & $past(dataLostFlag)) |-> spiCsN)
        else $error("lost flag cleared inside a frame");
    a_bit_hold: assert property (spiClk [*4] |-> $stable(misoOut))
        else $error("reply bit moved while clock high");
    a_global_frame: assert property (
        $changed(globalFault) |-> spiCsN)
        else $error("global fault changed inside a frame");
    a_dec_take: assert property (decValid && decReady |=> !decReady)
        else $error("decoder ready held after a take");
    a_reset_clear: assert property (disable iff (1'b0)
        !reset_n |=> !misoOe && dataLostFlag == 4'h0
        && statusBits == 2'h0 && !globalFault)
        else $error("outputs not cleared by reset");

    c_global: cover property ($rose(globalFault));
    c_lost: cover property ($fell(dataLostFlag[2]));
    c_take: cover property (decValid && decReady);
endmodule // srf_reply_formatter_props

bind srf_reply_formatter srf_reply_formatter_props #(
    .ING_DEPTH(ING_DEPTH),
    .Q_DEPTH  (Q_DEPTH)
) u_srf_reply_formatter_props (
    .ref_clk     (ref_clk),
    .reset_n     (reset_n),
    .spiClk      (spiClk),
    .spiCsN      (spiCsN),
    .misoOut     (misoOut),
    .misoOe      (misoOe),
    .decValid    (decValid),
    .decReady    (decReady),
    .dataLostFlag(dataLostFlag),
    .statusBits  (statusBits),
    .globalFault (globalFault)
);

// file: tb/srf_host_model.sv
`timescale 1ns/1ps
module srf_host_model (
    input  wire misoOut,
    input  wire misoOe,
    output reg  spiClk,
    output reg  spiCsN,
    output reg  parityOk
);
    reg lastBit;

    initial
    begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        parityOk = 1'b0;
        lastBit = 1'b0;
    end

    // Samples late in the high phase: the reply trails the serial clock
    // by several reference clocks. A released line reads as the inverse.
    task frame(input integer n, output reg [15:0] word);
        integer i;
        begin
            word = 16'h0000;
            spiCsN = 1'b0;
            #48;
            for (i = 0; i < n; i = i + 1)
            begin
                spiClk = 1'b1;
                #31;
                lastBit = misoOe ? misoOut : ~lastBit;
                if (i < 16)
                    word = {word[14:0], lastBit};
                #1;
                spiClk = 1'b0;
                #32;
            end
            spiCsN = 1'b1;
            parityOk = ^word;
            #96;
        end
    endtask
endmodule // srf_host_model

// file: tb/satellite_spi_reply_formatter_tb_top.sv
`timescale 1ns/1ps
module satellite_spi_reply_formatter_tb_top;
    localparam [12:0] MAIN = 13'h1_A5C;
    localparam [12:0] CHANNEL_CONFIG_REGISTER  = 13'h0_3C1;
    reg         ref_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg  [1:0]  replyChan = 2'h0;
    reg  [1:0]  replyMode = 2'h0;
    reg         replyCcrWrite = 1'b0;
    reg  [7:0]  chanCtrl = 8'h00;
    reg  [3:0]  protoB = 4'h0;
    reg  [7:0]  bDataBits = 8'h00;
    reg         flushReq = 1'b0;
    reg  [1:0]  flushChan = 2'h0;
    reg  [3:0]  curLimitEvt = 4'h0;
    reg  [3:0]  spiParityEvt = 4'h0;
    reg         decValid = 1'b0;
    reg  [1:0]  decChan = 2'h0;
    reg  [1:0]  decKind = 2'h0;
    reg  [11:0] decData = 12'h000;
    reg  [15:0] word;
    wire        spiClk, spiCsN, misoOut, misoOe, decReady;
    wire        globalFault, parityOk;
    wire [3:0]  dataLostFlag;
    wire [1:0]  statusBits;
    integer     n_mismatch = 0;
    integer     n_checks = 0;
    integer     cycles = 0;

    always #4 ref_clk = ~ref_clk;

    srf_reply_formatter u_srf_reply_formatter (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(1'b1),
        .spiClk(spiClk), .spiCsN(spiCsN), .misoOut(misoOut),
        .misoOe(misoOe), .replyChan(replyChan), .replyMode(replyMode),
        .replyCcrWrite(replyCcrWrite), .mainConfig(MAIN), .chanConfig(CHANNEL_CONFIG_REGISTER),
        .chanCtrl(chanCtrl), .protoB(protoB), .bDataBits(bDataBits),
        .flushReq(flushReq), .flushChan(flushChan),
        .curLimitEvt(curLimitEvt), .spiParityEvt(spiParityEvt),
        .decValid(decValid), .decReady(decReady), .decChan(decChan),
        .decKind(decKind), .decData(decData),
        .dataLostFlag(dataLostFlag), .statusBits(statusBits),
        .globalFault(globalFault)
    );

    srf_host_model u_srf_host_model (
        .misoOut(misoOut), .misoOe(misoOe), .spiClk(spiClk),
        .spiCsN(spiCsN), .parityOk(parityOk)
    );

    function [15:0] odd(input [15:0] w);
        odd = {w[15:14], ~^{w[15:14], w[12:0]}, w[12:0]};
    endfunction

    function [15:0] qw(input [1:0] c, input l, input [11:0] d);
        qw = odd({(c == 2'h3) ? 2'h0 : c, 1'b0, l, d});
    endfunction

    function [11:0] want(input b, input [1:0] w, input [1:0] k,
                         input [11:0] d);
        if (k != 2'h0)
            want = (k == 2'h1) ? 12'h019 : (k == 2'h2) ? 12'h01A : 12'h01C;
        else if (b)
            want = 12'h800 | (d & (12'h7FF >> (2'h3 - w)));
        else
            want = (d < 12'h020) ? 12'h018 : d;
    endfunction

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            complete_run;
        end
    end

    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask

    task tick(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask

    task xfer(input integer n);
        begin
            u_srf_host_model.frame(n, word);
            if (n == 16)
                chk({15'h0000, parityOk}, 16'h0001);
            tick(1);
        end
    endtask

    task pulse(input [3:0] cl, input [3:0] pe);
        begin
            curLimitEvt = cl;
            spiParityEvt = pe;
            tick(1);
            curLimitEvt = 4'h0;
            spiParityEvt = 4'h0;
            tick(4);
        end
    endtask

    task dec(input [1:0] k, input [11:0] d);
        integer t;
        begin
            decChan = 2'h3;
            decKind = k;
            decData = d;
            decValid = 1'b1;
            t = 0;
            @(posedge ref_clk);
            while (decReady !== 1'b1 && t < 40)
            begin
                t = t + 1;
                @(posedge ref_clk);
            end
            #1;
            decValid = 1'b0;
            chk(t[15:0] < 16'h0028, 16'h0001);
            tick(1);
        end
    endtask

    task s_reset;
        begin
            replyChan = 2'h1;
            replyMode = 2'h1;
            xfer(16);
            chk(word, odd({2'h3, 1'b0, MAIN}));
            replyMode = 2'h2;
            xfer(16);
            chk(word, 16'hE000);
            replyMode = 2'h0;
            replyCcrWrite = 1'b1;
            xfer(16);
            chk(word, odd({2'h3, 1'b0, CHANNEL_CONFIG_REGISTER}));
            replyChan = 2'h0;
            replyCcrWrite = 1'b0;
            xfer(16);
            chk(word, odd({2'h3, 1'b0, CHANNEL_CONFIG_REGISTER}));
            replyChan = 2'h1;
            replyMode = 2'h3;
            xfer(16);
            chk(word, odd({2'h3, 1'b0, MAIN}));
        end
    endtask

    task s_status;
        integer c;
        begin
            for (c = 0; c < 4; c = c + 1)
            begin
                chanCtrl = {4'h0, c[1:0], 2'h0};
                xfer(16);
                chk(word, qw(c[1:0], 1'b0, 12'h000));
                chk({14'h0000, statusBits},
                    {14'h0000, (c == 3) ? 2'h0 : c[1:0]});
            end
        end
    endtask

    task s_faults;
        begin
            replyChan = 2'h2;
            chanCtrl = 8'h20;
            pulse(4'h4, 4'h0);
            pulse(4'h0, 4'h4);
            pulse(4'h4, 4'h0);
            chk({12'h000, dataLostFlag}, 16'h0004);
            xfer(16);
            xfer(16);
            chk(word, qw(2'h2, 1'b1, 12'h010));
            chk({12'h000, dataLostFlag}, 16'h0000);
            xfer(16);
            chk(word, qw(2'h2, 1'b0, 12'h012));
            xfer(16);
            chk(word, qw(2'h2, 1'b0, 12'h000));
            pulse(4'h4, 4'h0);
            pulse(4'h0, 4'h4);
            flushChan = 2'h2;
            flushReq = 1'b1;
            tick(1);
            flushReq = 1'b0;
            tick(2);
            xfer(16);
            xfer(16);
            chk(word, qw(2'h2, 1'b0, 12'h000));
        end
    endtask

    function [11:0] dsel(input integer i);
        case (i)
            0: dsel = 12'h020;
            1: dsel = 12'hFFF;
            2: dsel = 12'h01F;
            7: dsel = 12'h005;
            default: dsel = 12'hFAB;
        endcase
    endfunction

    task s_decoder;
        localparam [23:0] KIND = 24'hE4_0E40;
        integer i;
        begin
            replyChan = 2'h3;
            chanCtrl = 8'hA0;
            for (i = 0; i < 12; i = i + 2)
            begin
                protoB = (i >= 6) ? 4'h8 : 4'h0;
                bDataBits = (i >= 8) ? 8'hC0 : 8'h00;
                dec(KIND[2*i +: 2], dsel(i));
                dec(KIND[2*i+2 +: 2], dsel(i + 1));
                tick(10);
                xfer(16);
                xfer(16);
                chk(word, qw(2'h2, 1'b0, want(protoB[3], bDataBits[7:6],
                    KIND[2*i +: 2], dsel(i))));
                xfer(16);
                chk(word, qw(2'h2, 1'b0, want(protoB[3], bDataBits[7:6],
                    KIND[2*i+2 +: 2], dsel(i + 1))));
            end
        end
    endtask

    task s_global;
        integer i, hits;
        begin
            replyChan = 2'h0;
            chanCtrl = 8'hA2;
            xfer(15);
            chk({15'h0000, globalFault}, 16'h0001);
            hits = 0;
            for (i = 0; i < 4; i = i + 1)
            begin
                xfer((i == 0) ? 17 : 16);
                if (word === qw(2'h2, 1'b0, 12'h002))
                    hits = hits + 1;
            end
            chk(hits[15:0], 16'h0001);
            chk(word, qw(2'h2, 1'b0, 12'h000));
            chk({15'h0000, globalFault}, 16'h0000);
        end
    endtask

    initial
    begin
        tick(12);
        reset_n = 1'b1;
        tick(4);
        s_reset;
        s_status;
        s_faults;
        s_decoder;
        s_global;
        complete_run;
    end
endmodule // satellite_spi_reply_formatter_tb_top
